// [include/or_return_rotate_defs.svh]
`ifndef OR_RETURN_ROTATE_DEFS_SVH
`define OR_RETURN_ROTATE_DEFS_SVH

`define ORR_DATA_W 8
`define ORR_ADDR_W 8
`define ORR_PC_W 12
`define ORR_MSB 7
`define ORR_ACC_RESET 8'h00
`define ORR_PC_RESET 12'h000
`define ORR_INT_VECTOR 12'h004
`define ORR_GIE_RESET 1'b0
`define ORR_ZERO_RESET 1'b0

`endif

// [include/or_return_rotate_pkg.sv]
`include "or_return_rotate_defs.svh"

package or_return_rotate_pkg;

   typedef enum logic [2:0] {
      OP_OR_IMMEDIATE,
      OP_OR_TO_MEMORY,
      OP_RETURN,
      OP_RETURN_WITH_LITERAL,
      OP_RETURN_FROM_INTERRUPT,
      OP_ROTATE_LEFT
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE
   } exec_state_t;

   typedef logic [`ORR_DATA_W-1:0] byte_t;
   typedef logic [`ORR_PC_W-1:0] pc_t;

endpackage : or_return_rotate_pkg

// [logic/or_rotate_unit.sv]
`timescale 1ns/1ns
`include "or_return_rotate_defs.svh"

module or_rotate_unit
   import or_return_rotate_pkg::*;
(
   input wire byte_t acc_i,
   input wire byte_t operand_i,
   output byte_t or_o,
   output byte_t rol_o,
   output logic or_zero_o
);

   assign or_o = acc_i | operand_i;
   assign or_zero_o = (or_o == `ORR_ACC_RESET);

   // Bit i moves to bit i+1, top bit wraps to bit 0
   genvar i;
   generate
      for (i = 0; i < `ORR_DATA_W; i = i + 1) begin : g_rol
         if (i == 0) begin : g_wrap
            assign rol_o[0] = operand_i[`ORR_MSB];
         end else begin : g_shift
            assign rol_o[i] = operand_i[i-1];
         end
      end
   endgenerate

endmodule : or_rotate_unit

// [logic/or_return_rotate_exec.sv]
`timescale 1ns/1ns
`include "or_return_rotate_defs.svh"

// Behaviour
// - OR immediate: accumulator gets accumulator OR immediate, zero flag updated.
// - OR to memory: memory byte gets accumulator OR byte, accumulator kept.
// - Plain return: program counter popped from stack, flags untouched.
// - Literal return: pop program counter, load immediate into accumulator, flags kept.
// - Interrupt return: pop program counter, set global interrupt enable, flags kept.
// - Pending interrupt after interrupt return is serviced before the main program.
// - Rotate left: memory byte rotated in place, bit 7 to bit 0, flags kept.
// - Global interrupt enable gates every interrupt entry.
module or_return_rotate_exec
   import or_return_rotate_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic op_valid_i,
   input wire op_t op_code_i,
   input wire byte_t imm_i,
   input wire logic [`ORR_ADDR_W-1:0] mem_addr_i,
   output logic op_ready_o,
   output logic done_o,
   output logic mem_rd_o,
   output logic mem_we_o,
   output logic [`ORR_ADDR_W-1:0] mem_addr_o,
   output byte_t mem_wdata_o,
   input wire byte_t mem_rdata_i,
   input wire pc_t pc_i,
   input wire pc_t stack_top_i,
   output logic stack_pop_o,
   output logic stack_push_o,
   output pc_t stack_wdata_o,
   input wire logic irq_pending_i,
   output logic int_entry_o,
   output pc_t pc_o,
   output logic pc_load_o,
   output byte_t acc_o,
   output logic zero_flag_o,
   output logic global_interrupt_enable_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   exec_state_t state_r;
   exec_state_t state_nxt;
   op_t mem_op_r;
   logic [`ORR_ADDR_W-1:0] mem_addr_r;
   byte_t mem_wdata_r;
   logic mem_we_r;
   byte_t acc_r;
   logic zero_r;
   logic gie_r;
   pc_t pc_r;
   logic pc_load_r;
   logic pop_r;
   logic push_r;
   pc_t push_data_r;
   logic int_entry_r;
   logic done_r;
   logic irq_take;
   logic op_take;
   logic is_mem_op;
   byte_t or_imm;
   byte_t or_mem;
   byte_t rol_mem;
   logic zero_imm;
   logic zero_mem;

   ////////////////////////////////////////////////////////////////////////////////
   // Datapath

   or_rotate_unit u_imm_unit (
      .acc_i(acc_r),
      .operand_i(imm_i),
      .or_o(or_imm),
      .rol_o(),
      .or_zero_o(zero_imm)
   );

   // Memory byte arrives one cycle after the read strobe
   or_rotate_unit u_mem_unit (
      .acc_i(acc_r),
      .operand_i(mem_rdata_i),
      .or_o(or_mem),
      .rol_o(rol_mem),
      .or_zero_o(zero_mem)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Issue control

   // Interrupt entry outranks a new instruction, so a request left pending
   // by the interrupt return is serviced before the next main-program op
   assign irq_take = (state_r == ST_IDLE) && gie_r && irq_pending_i;
   assign op_ready_o = (state_r == ST_IDLE) && !irq_take;
   assign op_take = op_valid_i && op_ready_o;
   assign is_mem_op = (op_code_i == OP_OR_TO_MEMORY) || (op_code_i == OP_ROTATE_LEFT);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (op_take && is_mem_op) begin
               state_nxt = ST_READ;
            end
         end
         ST_READ: begin
            state_nxt = ST_WRITE;
         end
         ST_WRITE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_op_r <= OP_OR_TO_MEMORY;
         mem_addr_r <= '0;
      end else if (op_take && is_mem_op) begin
         mem_op_r <= op_code_i;
         mem_addr_r <= mem_addr_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory write-back

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_we_r <= 1'b0;
         mem_wdata_r <= `ORR_ACC_RESET;
      end else begin
         mem_we_r <= 1'b0;
         if (state_r == ST_WRITE) begin
            mem_we_r <= 1'b1;
            if (mem_op_r == OP_ROTATE_LEFT) begin
               mem_wdata_r <= rol_mem;
            end else begin
               mem_wdata_r <= or_mem;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Accumulator and zero flag

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_r <= `ORR_ACC_RESET;
      end else if (op_take) begin
         if (op_code_i == OP_OR_IMMEDIATE) begin
            acc_r <= or_imm;
         end else if (op_code_i == OP_RETURN_WITH_LITERAL) begin
            acc_r <= imm_i;
         end
      end
   end

   // Returns and rotate leave the flag alone
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         zero_r <= `ORR_ZERO_RESET;
      end else if (op_take && (op_code_i == OP_OR_IMMEDIATE)) begin
         zero_r <= zero_imm;
      end else if ((state_r == ST_WRITE) && (mem_op_r == OP_OR_TO_MEMORY)) begin
         zero_r <= zero_mem;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Program counter and stack

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_r <= `ORR_PC_RESET;
         pc_load_r <= 1'b0;
         pop_r <= 1'b0;
      end else begin
         pc_load_r <= 1'b0;
         pop_r <= 1'b0;
         if (irq_take) begin
            pc_r <= `ORR_INT_VECTOR;
            pc_load_r <= 1'b1;
         end else if (op_take && ((op_code_i == OP_RETURN) ||
                                  (op_code_i == OP_RETURN_WITH_LITERAL) ||
                                  (op_code_i == OP_RETURN_FROM_INTERRUPT))) begin
            pc_r <= stack_top_i;
            pc_load_r <= 1'b1;
            pop_r <= 1'b1;
         end
      end
   end

   // Return address pushed so the interrupted code resumes afterwards
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         push_r <= 1'b0;
         push_data_r <= `ORR_PC_RESET;
         int_entry_r <= 1'b0;
      end else begin
         push_r <= irq_take;
         int_entry_r <= irq_take;
         if (irq_take) begin
            push_data_r <= pc_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Global interrupt enable

   // Entry and interrupt return never share a cycle, so no set/clear clash
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gie_r <= `ORR_GIE_RESET;
      end else if (op_take && (op_code_i == OP_RETURN_FROM_INTERRUPT)) begin
         gie_r <= 1'b1;
      end else if (irq_take) begin
         gie_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Completion

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
      end else begin
         done_r <= (op_take && !is_mem_op) || (state_r == ST_WRITE);
      end
   end

   assign done_o = done_r;
   assign mem_rd_o = (state_r == ST_READ);
   assign mem_we_o = mem_we_r;
   assign mem_addr_o = mem_addr_r;
   assign mem_wdata_o = mem_wdata_r;
   assign stack_pop_o = pop_r;
   assign stack_push_o = push_r;
   assign stack_wdata_o = push_data_r;
   assign int_entry_o = int_entry_r;
   assign pc_o = pc_r;
   assign pc_load_o = pc_load_r;
   assign acc_o = acc_r;
   assign zero_flag_o = zero_r;
   assign global_interrupt_enable_o = gie_r;

endmodule : or_return_rotate_exec

// [testbench/orr_checker.sv]
`timescale 1ns/1ns
module orr_checker
   import or_return_rotate_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic op_valid_i,
   input wire op_t op_code_i,
   input wire byte_t imm_i,
   input wire logic op_ready_o,
   input wire logic done_o,
   input wire logic mem_we_o,
   input wire byte_t mem_wdata_o,
   input wire byte_t mem_rdata_i,
   input wire pc_t stack_top_i,
   input wire logic irq_pending_i,
   input wire logic int_entry_o,
   input wire pc_t pc_o,
   input wire logic pc_load_o,
   input wire byte_t acc_o,
   input wire logic zero_flag_o,
   input wire logic global_interrupt_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   byte_t rd_r;
   assign take = op_valid_i && op_ready_o;
   // Read data lands one cycle before the write
   always_ff @(posedge clk_i) begin
      rd_r <= mem_rdata_i;
   end
   ////////////////////////////////////////////////////////////////
   chk_or_imm_acc: assert property (take && op_code_i == OP_OR_IMMEDIATE
      |=> done_o && acc_o == ($past(acc_o) | $past(imm_i))) else $error("or immediate");
   chk_or_zero: assert property (take && op_code_i == OP_OR_IMMEDIATE
      |=> zero_flag_o == (acc_o == 8'h00)) else $error("zero flag");
   chk_ret_pc: assert property (take && op_code_i == OP_RETURN
      |=> pc_load_o && pc_o == $past(stack_top_i) && $stable(zero_flag_o)) else $error("return");
   chk_lit_acc: assert property (take && op_code_i == OP_RETURN_WITH_LITERAL
      |=> acc_o == $past(imm_i) && $stable(zero_flag_o)) else $error("literal return");
   chk_return_from_interrupt_gie: assert property (take && op_code_i == OP_RETURN_FROM_INTERRUPT
      |=> global_interrupt_enable_o) else $error("gie not set");
   chk_return_from_interrupt_pending: assert property (take && op_code_i == OP_RETURN_FROM_INTERRUPT
      ##1 irq_pending_i |=> int_entry_o && pc_o == 12'h004) else $error("pending irq");
   chk_gie_gate: assert property (int_entry_o
      |-> $past(global_interrupt_enable_o)) else $error("entry with gie low");
   chk_orm_write: assert property (take && op_code_i == OP_OR_TO_MEMORY
      |-> ##3 mem_we_o && mem_wdata_o == (acc_o | rd_r) && acc_o == $past(acc_o, 3))
      else $error("or to memory");
   chk_rol_write: assert property (take && op_code_i == OP_ROTATE_LEFT
      |-> ##3 mem_we_o && mem_wdata_o == {rd_r[6:0], rd_r[7]}
      && zero_flag_o == $past(zero_flag_o, 3)) else $error("rotate left");
endmodule : orr_checker

bind or_return_rotate_exec orr_checker u_orr_checker (.clk_i, .rst_i, .op_valid_i,
   .op_code_i, .imm_i, .op_ready_o, .done_o, .mem_we_o, .mem_wdata_o, .mem_rdata_i,
   .stack_top_i, .irq_pending_i, .int_entry_o, .pc_o, .pc_load_o, .acc_o, .zero_flag_o,
   .global_interrupt_enable_o);

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top
   import or_return_rotate_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic op_valid_i = 1'b0;
   op_t op_code_i = OP_OR_IMMEDIATE;
   byte_t imm_i = 8'h00;
   byte_t mem_addr_i = 8'h3C;
   byte_t mem_rdata_i = 8'h00;
   pc_t pc_i = 12'h200;
   pc_t stack_top_i = 12'h123;
   logic irq_pending_i = 1'b0;
   logic op_ready_o, done_o, mem_rd_o, mem_we_o, stack_pop_o, stack_push_o;
   logic int_entry_o, pc_load_o, zero_flag_o, global_interrupt_enable_o;
   logic [7:0] mem_addr_o;
   byte_t mem_wdata_o, acc_o;
   pc_t stack_wdata_o, pc_o;
   int error_cnt = 0;
   int samples_checked = 0;
   always #50 clk_i = ~clk_i;
   or_return_rotate_exec u_or_return_rotate_exec (.clk_i, .rst_i, .op_valid_i, .op_code_i,
      .imm_i, .mem_addr_i, .op_ready_o, .done_o, .mem_rd_o, .mem_we_o, .mem_addr_o,
      .mem_wdata_o, .mem_rdata_i, .pc_i, .stack_top_i, .stack_pop_o, .stack_push_o,
      .stack_wdata_o, .irq_pending_i, .int_entry_o, .pc_o, .pc_load_o, .acc_o,
      .zero_flag_o, .global_interrupt_enable_o);
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   // Read data held for the whole op, so the sync read sees it
   task automatic run_op(input op_t op, input byte_t imm, input byte_t rd);
      int n;
      logic is_mem;
      logic is_ret;
      n = 0;
      is_mem = (op == OP_OR_TO_MEMORY) || (op == OP_ROTATE_LEFT);
      is_ret = op inside {OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT};
      @(posedge clk_i);
      op_valid_i <= 1'b1;
      op_code_i <= op;
      imm_i <= imm;
      mem_rdata_i <= rd;
      // Request stands until an edge that sees ready high; ready read mid-cycle
      @(negedge clk_i);
      while (op_ready_o !== 1'b1 && n < 8) begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
      op_valid_i <= 1'b0;
      #1;
      n = 0;
      check(mem_rd_o, is_mem);
      check(stack_pop_o, is_ret);
      while (done_o !== 1'b1 && n < 8) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      check(done_o, 1'b1);
   endtask : run_op
   ////////////////////////////////////////////////////////////////
   task automatic test_data;
      run_op(OP_OR_IMMEDIATE, 8'h00, 8'h00);
      check(zero_flag_o, 1'b1);
      run_op(OP_OR_IMMEDIATE, 8'h5A, 8'h00);
      check(acc_o, 8'h5A);
      check(zero_flag_o, 1'b0);
      run_op(OP_OR_TO_MEMORY, 8'h00, 8'h21);
      check(mem_we_o, 1'b1);
      check(mem_wdata_o, 8'h7B);
      check(mem_addr_o, 8'h3C);
      check(acc_o, 8'h5A);
   endtask : test_data
   task automatic test_returns;
      run_op(OP_RETURN, 8'hFF, 8'h00);
      check(pc_o, 12'h123);
      check(pc_load_o, 1'b1);
      check(acc_o, 8'h5A);
      @(posedge clk_i);
      stack_top_i <= 12'h456;
      run_op(OP_RETURN_WITH_LITERAL, 8'h00, 8'h00);
      check(pc_o, 12'h456);
      check(acc_o, 8'h00);
      check(zero_flag_o, 1'b0);
   endtask : test_returns
   // Zero accumulator and zero byte reach the zero flag through memory
   task automatic test_memory;
      run_op(OP_OR_TO_MEMORY, 8'h00, 8'h00);
      check(zero_flag_o, 1'b1);
      run_op(OP_ROTATE_LEFT, 8'h00, 8'h81);
      check(mem_wdata_o, 8'h03);
      check(zero_flag_o, 1'b1);
      run_op(OP_ROTATE_LEFT, 8'h00, 8'h40);
      check(mem_wdata_o, 8'h80);
   endtask : test_memory
   task automatic test_interrupt;
      @(posedge clk_i);
      irq_pending_i <= 1'b1;
      stack_top_i <= 12'h0AB;
      repeat (4) begin
         @(posedge clk_i);
         #1;
         check(int_entry_o, 1'b0);
      end
      run_op(OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00);
      check(global_interrupt_enable_o, 1'b1);
      check(pc_o, 12'h0AB);
      check(op_ready_o, 1'b0);
      @(posedge clk_i);
      irq_pending_i <= 1'b0;
      #1;
      check(int_entry_o, 1'b1);
      check(stack_push_o, 1'b1);
      check(stack_wdata_o, 12'h200);
      check(pc_o, 12'h004);
      check(global_interrupt_enable_o, 1'b0);
   endtask : test_interrupt
   ////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      test_data();
      test_returns();
      test_memory();
      test_interrupt();
      complete_run();
   end
   // Whole run needs well under 100 cycles
   initial begin
      repeat (400) @(posedge clk_i);
      error_cnt++;
      complete_run();
   end
endmodule : tb_top
